/* pkg/swc_pkg.sv */
// Package for the standby and wakeup control block: register offsets,
// field positions, reset values and timing counts.
// Assumes an 8-bit special-function-register bus with byte offsets.
package swc_pkg;

  // Register offsets on the SFR bus
  localparam logic [7:0] SWC_ADDR_POWER_CTRL_MISC = 8'h87;
  localparam logic [7:0] SWC_ADDR_STANDBY_ENTRY = 8'hA4;
  localparam logic [7:0] SWC_ADDR_WAKEUP_CONFIG = 8'hA5;
  localparam logic [7:0] SWC_ADDR_RESET_CAUSE = 8'hB1;

  // Reset values
  localparam logic [7:0] SWC_RST_POWER_CTRL_MISC = 8'h00;
  localparam logic [7:0] SWC_RST_WAKEUP_CONFIG = 8'h00;

  // Field positions
  localparam int SWC_BIT_SLOW_CLK = 3;
  localparam int SWC_BIT_WATCHDOG_CAUSE = 0;
  localparam int SWC_BIT_BAUD_DOUBLE = 7;
  localparam int SWC_BIT_PROG_WRITE = 4;
  localparam int SWC_FLD_RADIO_LSB = 6;
  localparam int SWC_FLD_WAKE_LSB = 4;
  localparam int SWC_FLD_BUS_IRQ_LSB = 2;
  localparam int SWC_FLD_BUS_RESUME_LSB = 0;

  // Read-write mask of the power control register: bits 7:2
  localparam logic [7:0] SWC_MASK_POWER_CTRL_MISC = 8'hFC;

  // Wakeup field codes
  localparam logic [1:0] SWC_WAKE_IF_ENABLED = 2'h0;
  localparam logic [1:0] SWC_WAKE_ALWAYS = 2'h2;
  localparam logic [1:0] SWC_WAKE_IGNORE = 2'h3;

  // Clock rates and slow-clock divider
  localparam int SWC_SYS_CLK_HZ = 200_000_000;
  localparam int SWC_OSC_HZ = 16_000_000;
  localparam int SWC_SLOW_CLK_HZ = 32_000;
  // System cycles per half period of the slow clock
  localparam int SWC_SLOW_HALF_CYC = SWC_SYS_CLK_HZ / (2 * SWC_SLOW_CLK_HZ);
  localparam int SWC_SLOW_CNT_W = 12;

  // MCU power state
  typedef enum logic [0:0] {
    SWC_ST_ACTIVE = 1'b0,
    SWC_ST_STANDBY = 1'b1
  } swc_state_e;

endpackage : swc_pkg

/* core/swc_slow_clock.sv */
// Slow 32 kHz clock generator, a square wave derived from the system clock
// that stands in for the always-running oscillator.
// Assumes the system clock never stops, unlike the MCU clock.
`timescale 1ns/10ps
`default_nettype none
module swc_slow_clock (
  input wire logic i_clk_sys,
  input wire logic i_reset,
  output logic o_slow_clock_32k
);
  import swc_pkg::*;

  logic [SWC_SLOW_CNT_W-1:0] cnt_q; // Half-period counter
  logic slow_q; // Slow clock level

  // Divider: toggle every half period
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      cnt_q <= '0;
      slow_q <= 1'b0;
    end else if (cnt_q == SWC_SLOW_CNT_W'(SWC_SLOW_HALF_CYC - 1)) begin
      cnt_q <= '0;
      slow_q <= ~slow_q;
    end else begin
      cnt_q <= cnt_q + SWC_SLOW_CNT_W'(1);
    end
  end

  assign o_slow_clock_32k = slow_q;
endmodule : swc_slow_clock
`default_nettype wire

/* core/swc_wake_gate.sv */
// Gate for one wakeup source under its two-bit configuration field.
// Assumes the event is a one-cycle pulse on the system clock.
`timescale 1ns/10ps
`default_nettype none
module swc_wake_gate (
  input wire logic [1:0] i_mode,
  input wire logic i_enable,
  input wire logic i_event,
  output logic o_wake
);
  import swc_pkg::*;

  // Reserved code 01 is treated as ignore, the safe reading
  always_comb begin
    case (i_mode)
      SWC_WAKE_IF_ENABLED: o_wake = i_event & i_enable;
      SWC_WAKE_ALWAYS: o_wake = i_event;
      default: o_wake = 1'b0;
    endcase
  end
endmodule : swc_wake_gate

/* core/swc_standby_wakeup.sv */
// Standby, wakeup and reset-cause control registers of an 8051-style core.
// Assumes reset-source and event inputs are on i_clk_sys, except
// i_power_fail and i_reset_pin_n which come from pads and are synchronised.
`timescale 1ns/10ps
`default_nettype none
module swc_standby_wakeup (
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  input wire logic i_por_reset,
  input wire logic i_reset_pin_n,
  input wire logic i_watchdog_reset,
  input wire logic i_power_fail,
  input wire logic [7:0] i_interrupt_enable_second,
  input wire logic i_radio_interrupt,
  input wire logic i_internal_wakeup_event,
  input wire logic i_bus_interrupt,
  input wire logic i_bus_resume_wake,
  input wire logic i_pin_wake,
  input wire logic i_rtc_wake,
  input wire logic i_prog_mem_wr_req,
  output logic o_sys_reset,
  output logic o_mcu_clk_run,
  output logic o_standby,
  output logic [3:0] o_irq_flag_set,
  output logic o_baud_double,
  output logic o_prog_write_mode,
  output logic o_prog_mem_wr
);
  import swc_pkg::*;

  // Interrupt-enable bit positions for the four wake sources
  localparam int IEN_RADIO = 1;
  localparam int IEN_WAKE = 5;
  localparam int IEN_BUS_IRQ = 4;
  localparam int IEN_BUS_RESUME = 3;

  logic [1:0] pin_sync_q; // Reset pin synchroniser
  logic [1:0] pfail_sync_q; // Power-fail synchroniser
  logic any_reset; // Combined reset request
  logic rst_d1_q; // Delayed combined reset for release detection
  logic wdog_seen_q; // Watchdog was the only source of this reset
  logic cause_q; // Reset cause bit
  logic [7:0] power_ctrl_q; // Power control register
  logic [7:0] wake_cfg_q; // Wakeup configuration register
  swc_state_e state_q; // MCU power state
  logic [7:0] rdata_q; // Read data
  logic [3:0] wake_hit; // Per-source gated wake
  logic [3:0] wake_evt; // Raw events
  logic [3:0] wake_en; // Matching interrupt enables
  logic slow_clk; // Slow clock level
  logic wr_standby; // Write of standby register with nonzero code
  logic wake_any; // Any wake request

  // Decode shared by read and write paths
  function automatic logic addr_is(input logic [7:0] a, input logic [7:0] ref_a);
    addr_is = (a == ref_a);
  endfunction : addr_is

  // Pad inputs pass two flops before use; the first stage feeds only the second
  always_ff @(posedge i_clk_sys) begin
    pin_sync_q <= {pin_sync_q[0], ~i_reset_pin_n};
    pfail_sync_q <= {pfail_sync_q[0], i_power_fail};
  end

  // Every source drives the same reset; only i_reset also restarts the slow clock divider
  assign any_reset = i_reset | i_por_reset | pin_sync_q[1] | i_watchdog_reset;
  assign o_sys_reset = any_reset;

  // Track reset release and whether the watchdog was the only source
  always_ff @(posedge i_clk_sys) begin
    rst_d1_q <= any_reset;
  end

  // Watchdog memory during a reset; a later non-watchdog reset clears it
  always_ff @(posedge i_clk_sys) begin
    if (any_reset && !rst_d1_q) begin
      wdog_seen_q <= i_watchdog_reset & ~(i_reset | i_por_reset | pin_sync_q[1]);
    end else if (any_reset) begin
      if (i_reset || i_por_reset || pin_sync_q[1]) begin
        wdog_seen_q <= 1'b0; // Other source wins the cause
      end
    end
  end

  // Cause bit is caught at release and then held until the next reset is released
  always_ff @(posedge i_clk_sys) begin
    if (!any_reset && rst_d1_q) begin
      cause_q <= wdog_seen_q;
    end
  end

  // Power control register; reserved low bits are never stored
  always_ff @(posedge i_clk_sys) begin
    if (any_reset) begin
      power_ctrl_q <= SWC_RST_POWER_CTRL_MISC;
    end else if (i_wr && addr_is(i_addr, SWC_ADDR_POWER_CTRL_MISC)) begin
      power_ctrl_q <= i_wdata & SWC_MASK_POWER_CTRL_MISC;
    end
  end

  // Wakeup configuration register, all eight bits read-write
  always_ff @(posedge i_clk_sys) begin
    if (any_reset) begin
      wake_cfg_q <= SWC_RST_WAKEUP_CONFIG;
    end else if (i_wr && addr_is(i_addr, SWC_ADDR_WAKEUP_CONFIG)) begin
      wake_cfg_q <= i_wdata;
    end
  end

  // Outputs steered by the power control register
  assign o_baud_double = power_ctrl_q[SWC_BIT_BAUD_DOUBLE];
  assign o_prog_write_mode = power_ctrl_q[SWC_BIT_PROG_WRITE];
  // Write strobe to program memory is dropped while supply is failing
  assign o_prog_mem_wr = i_prog_mem_wr_req & power_ctrl_q[SWC_BIT_PROG_WRITE]
                         & ~pfail_sync_q[1];

  // Slow clock source
  swc_slow_clock u_slow (
    .i_clk_sys(i_clk_sys),
    .i_reset(i_reset),
    .o_slow_clock_32k(slow_clk)
  );

  // Wake sources in order: radio, internal, bus irq, bus resume
  assign wake_evt = {i_radio_interrupt, i_internal_wakeup_event,
                     i_bus_interrupt, i_bus_resume_wake};
  assign wake_en = {i_interrupt_enable_second[IEN_RADIO],
                    i_interrupt_enable_second[IEN_WAKE],
                    i_interrupt_enable_second[IEN_BUS_IRQ],
                    i_interrupt_enable_second[IEN_BUS_RESUME]};

  // One gate per source; field i sits at bits 2i+1:2i
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_wake
      swc_wake_gate u_gate (
        .i_mode(wake_cfg_q[2*gi+1 -: 2]),
        .i_enable(wake_en[gi]),
        .i_event(wake_evt[gi]),
        .o_wake(wake_hit[gi])
      );
    end
  endgenerate

  // Pin and timer wakes arrive already qualified by their own logic
  assign wake_any = (|wake_hit) | i_pin_wake | i_rtc_wake;

  // Request flags are raised in standby only, for gated wakes of the four sources; pin and timer wakes raise none
  assign o_irq_flag_set = (state_q == SWC_ST_STANDBY) ? wake_hit : 4'h0;

  // Nonzero code in bits 2:0 stops the core clock; zero is a no-op
  assign wr_standby = i_wr && addr_is(i_addr, SWC_ADDR_STANDBY_ENTRY)
                      && (i_wdata[2:0] != 3'h0);

  // Power state; software must have cleared pending flags first,
  // otherwise a level-held request would end standby one cycle after entry
  always_ff @(posedge i_clk_sys) begin
    if (any_reset) begin
      state_q <= SWC_ST_ACTIVE;
    end else begin
      case (state_q)
        SWC_ST_ACTIVE: begin
          if (wr_standby) begin
            state_q <= SWC_ST_STANDBY;
          end
        end
        SWC_ST_STANDBY: begin
          if (wake_any) begin
            state_q <= SWC_ST_ACTIVE;
          end
        end
        default: state_q <= SWC_ST_ACTIVE;
      endcase
    end
  end

  assign o_standby = (state_q == SWC_ST_STANDBY);
  assign o_mcu_clk_run = (state_q == SWC_ST_ACTIVE);

  // Read data, one cycle after the strobe; unmapped reads return zero
  always_ff @(posedge i_clk_sys) begin
    if (any_reset) begin
      rdata_q <= 8'h00;
    end else if (i_rd) begin
      if (addr_is(i_addr, SWC_ADDR_POWER_CTRL_MISC)) begin
        rdata_q <= power_ctrl_q;
      end else if (addr_is(i_addr, SWC_ADDR_STANDBY_ENTRY)) begin
        rdata_q <= {4'h0, slow_clk, 3'h0};
      end else if (addr_is(i_addr, SWC_ADDR_WAKEUP_CONFIG)) begin
        rdata_q <= wake_cfg_q;
      end else if (addr_is(i_addr, SWC_ADDR_RESET_CAUSE)) begin
        rdata_q <= {7'h00, cause_q};
      end else begin
        rdata_q <= 8'h00;
      end
    end else begin
      rdata_q <= 8'h00;
    end
  end

  assign o_rdata = rdata_q;
endmodule : swc_standby_wakeup
`default_nettype wire

/* tb/swc_checker_sva.sv */
// Port checker for the standby and wakeup block, bound to its top module.
// Assumes one-cycle bus strobes and one-cycle event pulses.
`timescale 1ns/10ps
`default_nettype none
module swc_checker
  import swc_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic i_power_fail,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic [7:0] o_rdata,
  input wire logic [7:0] i_interrupt_enable_second,
  input wire logic i_radio_interrupt,
  input wire logic i_internal_wakeup_event,
  input wire logic i_bus_interrupt,
  input wire logic i_bus_resume_wake,
  input wire logic o_sys_reset,
  input wire logic o_standby,
  input wire logic [3:0] o_irq_flag_set,
  input wire logic o_baud_double,
  input wire logic o_prog_write_mode,
  input wire logic o_prog_mem_wr
);
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_reset);
  logic [7:0] cfg_q; // Shadow of the wakeup configuration
  logic [3:0] ev, en, wk; // Events, their enables, expected wakes
  logic [1:0] pc_bits; // Baud and write-mode bits of the bus data
  assign pc_bits = {i_wdata[7], i_wdata[4]};
  assign ev = {i_radio_interrupt, i_internal_wakeup_event, i_bus_interrupt, i_bus_resume_wake};
  assign en = {i_interrupt_enable_second[1], i_interrupt_enable_second[5:3]};
  // Shadow follows bus writes; any reset source clears it like the block
  always_ff @(posedge i_clk_sys) begin
    if (i_reset || o_sys_reset) begin
      cfg_q <= 8'h00;
    end else if (i_wr && i_addr == SWC_ADDR_WAKEUP_CONFIG) begin
      cfg_q <= i_wdata;
    end
  end
  // Reserved code is never written, so it needs no case here
  always_comb begin
    for (int k = 0; k < 4; k++) begin
      wk[k] = ev[k] && (cfg_q[2*k+:2] == SWC_WAKE_ALWAYS
        || (cfg_q[2*k+:2] == SWC_WAKE_IF_ENABLED && en[k]));
    end
  end
  property p_enter; i_wr && !o_sys_reset && i_addr == SWC_ADDR_STANDBY_ENTRY
    && i_wdata[2:0] != 3'h0 |=> o_standby; endproperty
  a_enter: assert property (p_enter) else $error("standby not entered");
  property p_gate; o_standby |-> o_irq_flag_set == wk; endproperty
  a_gate: assert property (p_gate) else $error("wake gating wrong");
  property p_wake; o_standby && o_irq_flag_set != 4'h0 |=> !o_standby; endproperty
  a_wake: assert property (p_wake) else $error("no return to active");
  property p_pf; i_power_fail [*3] |-> !o_prog_mem_wr; endproperty
  a_pf: assert property (p_pf) else $error("write during power fail");
  property p_mode; i_wr && !o_sys_reset && i_addr == SWC_ADDR_POWER_CTRL_MISC |=>
    {o_baud_double, o_prog_write_mode} == $past(pc_bits); endproperty
  a_mode: assert property (p_mode) else $error("power bits wrong");
  property p_rd_pc; i_rd && i_addr == SWC_ADDR_POWER_CTRL_MISC |=> o_rdata[1:0] == 2'h0; endproperty
  a_rd_pc: assert property (p_rd_pc) else $error("reserved bits set");
  property p_rd_sb; i_rd && i_addr == SWC_ADDR_STANDBY_ENTRY |=> (o_rdata & 8'hF7) == 8'h00;
  endproperty
  a_rd_sb: assert property (p_rd_sb) else $error("standby read bits set");
  property p_rd_rc; i_rd && i_addr == SWC_ADDR_RESET_CAUSE |=> o_rdata[7:1] == 7'h00; endproperty
  a_rd_rc: assert property (p_rd_rc) else $error("cause upper bits set");
endmodule : swc_checker
bind swc_standby_wakeup swc_checker chk_i (.i_clk_sys, .i_reset, .i_wr, .i_rd, .i_power_fail,
  .i_addr, .i_wdata, .o_rdata, .i_interrupt_enable_second, .i_radio_interrupt,
  .i_internal_wakeup_event, .i_bus_interrupt, .i_bus_resume_wake, .o_sys_reset,
  .o_standby, .o_irq_flag_set, .o_baud_double, .o_prog_write_mode, .o_prog_mem_wr);
`default_nettype wire

/* tb/swc_event_source.sv */
// Event-source model for the core side: wake events on command.
// Assumes commands change right after a rising edge.
`timescale 1ns/10ps
`default_nettype none
module swc_event_source (
  input wire logic i_clk_sys,
  input wire logic [5:0] i_cmd,
  output logic [5:0] o_pulse
);
  logic [5:0] cmd_q; // Command seen last cycle
  // One pulse per rising command edge; none lingers to leave a flag pending
  always_ff @(posedge i_clk_sys) begin
    cmd_q <= i_cmd;
    o_pulse <= i_cmd & ~cmd_q;
  end
endmodule : swc_event_source
`default_nettype wire

/* tb/test_mcu_standby_wakeup_control.sv */
// Self-checking bench for the standby and wakeup block.
// Assumes the checker binds itself and the event model drives events.
`timescale 1ns/10ps
`default_nettype none
module test_mcu_standby_wakeup_control;
  import swc_pkg::*;
  logic i_clk_sys, i_reset, i_wr, i_rd, i_por_reset, i_reset_pin_n, i_watchdog_reset;
  logic i_power_fail, i_prog_mem_wr_req, o_sys_reset, o_mcu_clk_run, o_standby;
  logic o_baud_double, o_prog_write_mode, o_prog_mem_wr;
  logic [7:0] i_addr, i_wdata, o_rdata, i_interrupt_enable_second;
  logic [3:0] o_irq_flag_set;
  logic [5:0] cmd, ev; // Event commands and resulting pulses
  logic [31:0] seed; // Stimulus state
  logic [7:0] regs [5] = '{8'h87, 8'hA4, 8'hA5, 8'hB1, 8'h3C}; // Last one unmapped
  int ieb [4] = '{3, 4, 5, 1}; // Enable bit of each wake source
  int n_fail, n_compared;
  swc_standby_wakeup uut (.i_clk_sys, .i_reset, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
    .i_por_reset, .i_reset_pin_n, .i_watchdog_reset, .i_power_fail, .i_interrupt_enable_second,
    .i_radio_interrupt(ev[3]), .i_internal_wakeup_event(ev[2]), .i_bus_interrupt(ev[1]),
    .i_bus_resume_wake(ev[0]), .i_pin_wake(ev[4]), .i_rtc_wake(ev[5]), .i_prog_mem_wr_req,
    .o_sys_reset, .o_mcu_clk_run, .o_standby, .o_irq_flag_set, .o_baud_double,
    .o_prog_write_mode, .o_prog_mem_wr);
  swc_event_source src (.i_clk_sys, .i_cmd(cmd), .o_pulse(ev));
  // 200 MHz clock
  initial begin
    i_clk_sys = 1'h0;
    forever #2.5 i_clk_sys = ~i_clk_sys;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  function automatic logic wake_exp(input logic [1:0] m, input logic en);
    return m == SWC_WAKE_ALWAYS || (m == SWC_WAKE_IF_ENABLED && en);
  endfunction : wake_exp
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk_sys);
    {i_wr, i_addr, i_wdata} <= {1'h1, a, d};
    @(posedge i_clk_sys);
    i_wr <= 1'h0;
  endtask : bus_wr
  task automatic bus_rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_clk_sys);
    {i_rd, i_addr} <= {1'h1, a};
    @(posedge i_clk_sys);
    i_rd <= 1'h0;
    #1 d = o_rdata;
  endtask : bus_rd
  // One reset source held, then cause and cleared power bits read back
  task automatic pulse_src(input int k);
    logic [7:0] r;
    bus_wr(SWC_ADDR_POWER_CTRL_MISC, 8'hFC);
    @(posedge i_clk_sys);
    {i_watchdog_reset, i_por_reset, i_reset_pin_n} <= {k == 0, k == 1, k != 2};
    repeat (3) @(posedge i_clk_sys);
    #1 chk(o_sys_reset, 1'h1);
    @(posedge i_clk_sys);
    {i_watchdog_reset, i_por_reset, i_reset_pin_n} <= 3'h1;
    repeat (6) @(posedge i_clk_sys);
    bus_rd(SWC_ADDR_RESET_CAUSE, r);
    chk(r, {7'h00, k == 0});
    bus_rd(SWC_ADDR_POWER_CTRL_MISC, r);
    chk(r, 8'h00);
  endtask : pulse_src
  task automatic finish_test;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : finish_test
  initial begin
    logic [15:0] c;
    logic [7:0] r;
    logic [1:0] m;
    logic w;
    int n;
    {i_reset, i_reset_pin_n, cmd, seed, n_fail, n_compared} = {2'h3, 6'h00, 32'he089, 64'h0};
    {i_wr, i_rd, i_por_reset, i_watchdog_reset, i_power_fail, i_prog_mem_wr_req} = 6'h00;
    {i_addr, i_wdata, i_interrupt_enable_second} = 24'h00_0000;
    repeat (20) @(posedge i_clk_sys);
    i_reset <= 1'h0;
    // Reset values after a refused write to the cause register
    bus_wr(SWC_ADDR_RESET_CAUSE, 8'hFF);
    foreach (regs[i]) begin
      bus_rd(regs[i], r);
      chk(r & 8'hF7, 8'h00);
    end
    for (int i = 0; i < 12; i++) begin
      seed = lfsr(seed);
      bus_wr(SWC_ADDR_POWER_CTRL_MISC, seed[7:0]);
      bus_rd(SWC_ADDR_POWER_CTRL_MISC, r);
      chk(r, seed[7:0] & 8'hFC);
      chk({o_baud_double, o_prog_write_mode}, {seed[7], seed[4]});
    end
    // Reads held back to back time one half period of the slow clock
    bus_rd(SWC_ADDR_STANDBY_ENTRY, r);
    @(posedge i_clk_sys);
    i_rd <= 1'h1;
    {c, n} = 0;
    for (int i = 0; i < 7000 && n < 2; i++) begin
      @(posedge i_clk_sys);
      #1 c++;
      if (o_rdata[3] !== r[3] && i > 0) begin
        n++;
        c = (n == 1) ? 16'h0000 : c;
      end
      r = o_rdata;
    end
    @(posedge i_clk_sys);
    i_rd <= 1'h0;
    chk(16'(n), 16'h0002);
    chk(c, 16'(SWC_SLOW_HALF_CYC));
    bus_wr(SWC_ADDR_STANDBY_ENTRY, 8'hF8);
    #1 chk({o_standby, o_mcu_clk_run}, 2'h1);
    // Each source under each defined code, enable random elsewhere
    for (int s = 0; s < 4; s++) begin
      for (int v = 0; v < 4; v++) begin
        m = (v < 2) ? SWC_WAKE_IF_ENABLED : (v == 2) ? SWC_WAKE_ALWAYS : SWC_WAKE_IGNORE;
        seed = lfsr(seed);
        @(posedge i_clk_sys);
        i_interrupt_enable_second <= seed[7:0] & ~(8'h01 << ieb[s]) | {7'h00, v[0]} << ieb[s];
        bus_wr(SWC_ADDR_WAKEUP_CONFIG, ~(8'h03 << 2 * s) | {6'h00, m} << 2 * s);
        bus_wr(SWC_ADDR_STANDBY_ENTRY, {5'h00, seed[10:8] | {2'h0, ~|seed[10:8]}});
        #1 chk({o_standby, o_mcu_clk_run}, 2'h2);
        @(posedge i_clk_sys);
        cmd <= 6'h01 << s;
        @(posedge i_clk_sys);
        cmd <= 6'h00;
        w = wake_exp(m, v[0]);
        #1 chk(o_irq_flag_set, {3'h0, w} << s);
        @(posedge i_clk_sys);
        cmd <= 6'h10 << v[0];
        #1 chk(o_standby, !w);
        repeat (2) @(posedge i_clk_sys);
        cmd <= 6'h00;
        #1 chk(o_standby, 1'h0);
      end
    end
    // Program-store write with supply good, then failing
    bus_wr(SWC_ADDR_POWER_CTRL_MISC, 8'h10);
    for (int p = 0; p < 2; p++) begin
      @(posedge i_clk_sys);
      {i_power_fail, i_prog_mem_wr_req} <= {p[0], 1'h1};
      repeat (4) @(posedge i_clk_sys);
      #1 chk(o_prog_mem_wr, !p[0]);
    end
    for (int k = 0; k < 4; k++) pulse_src((k * 2) % 3);
    finish_test();
  end
endmodule : test_mcu_standby_wakeup_control
`default_nettype wire
